// file: design/clock_source_switch_ctrl.sv
// clock source switching control with its command-latch behaviour
`timescale 1ns/1ps
`include "clock_switch_regs.svh"

// Summary of operation
// - enable/disable command held until next control access
// - select write reapplies held command to new source, except a held disable when the new source is the system source
// - leaving running crystal by select write spoils gain
// - memory programming succeeds only on RC after switching
module clock_source_switch_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_csr_wr,
	input wire logic i_csr_rd,
	input wire logic [`CSC_DATA_W-1:0] i_csr_wdata,
	input wire logic i_sel_wr,
	input wire logic [`CSC_SRC_W-1:0] i_sel_wdata,
	input wire logic i_nvm_req,
	output logic [`CSC_DATA_W-1:0] o_csr_rdata,
	output logic [`CSC_SRC_W-1:0] o_sel_value,
	output logic [`CSC_SRC_W-1:0] o_sys_src,
	output logic [`CSC_SRC_NUM-1:0] o_osc_en,
	output logic [`CSC_SRC_NUM-1:0] o_osc_ready,
	output logic o_xtal_gain_ok,
	output logic o_cmd_active,
	output logic o_nvm_busy,
	output logic o_nvm_done,
	output logic o_nvm_fail
);

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	localparam logic [`CSC_CNT_W-1:0] PROG_LAST = `CSC_CNT_W'(`CSC_NVM_PROG_CYC - 1);

	logic [`CSC_SRC_W-1:0] sel_reg;
	logic [`CSC_SRC_W-1:0] sel_next;
	logic [`CSC_SRC_W-1:0] sys_src_reg;
	logic [`CSC_SRC_W-1:0] sys_src_next;
	logic cmd_active_reg;
	logic cmd_active_next;
	logic cmd_enable_reg;
	logic cmd_enable_next;
	logic gain_ok_reg;
	logic gain_ok_next;
	logic switched_reg;
	logic switched_next;
	logic [`CSC_DATA_W-1:0] rdata_reg;
	logic [`CSC_DATA_W-1:0] rdata_next;

	clock_switch_pkg::nvm_state_t nvm_state_reg;
	clock_switch_pkg::nvm_state_t nvm_state_next;
	logic [`CSC_CNT_W-1:0] prog_cnt_reg;
	logic [`CSC_CNT_W-1:0] prog_cnt_next;
	logic prog_fail_reg;
	logic prog_fail_next;
	logic done_reg;
	logic done_next;
	logic fail_reg;
	logic fail_next;

	logic csr_access;
	logic change_en;
	clock_switch_pkg::clk_cmd_t csr_cmd;
	logic apply;
	logic [`CSC_SRC_W-1:0] apply_idx;
	logic apply_enable;
	logic [`CSC_SRC_NUM-1:0] osc_en;
	logic [`CSC_SRC_NUM-1:0] osc_ready;

	// -----------------------------------------------------------------
	// oscillator enables
	// -----------------------------------------------------------------
	osc_enable_bank u_osc_bank (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_apply(apply),
		.i_idx(apply_idx),
		.i_enable(apply_enable),
		.o_en(osc_en),
		.o_ready(osc_ready)
	);

	// -----------------------------------------------------------------
	// command decode and enable/disable application
	// -----------------------------------------------------------------
	assign csr_access = i_csr_wr | i_csr_rd;
	assign change_en = i_csr_wr & i_csr_wdata[`CSC_CHANGE_ENABLE_BIT];
	assign csr_cmd = clock_switch_pkg::clk_cmd_t'(i_csr_wdata[`CSC_CMD_MSB:`CSC_CMD_LSB]);

	always_comb begin
		apply = 1'b0;
		apply_idx = sel_reg;
		apply_enable = 1'b0;
		if (change_en && (csr_cmd == clock_switch_pkg::CMD_ENABLE)) begin
			apply = 1'b1;
			apply_enable = 1'b1;
		end else if (change_en && (csr_cmd == clock_switch_pkg::CMD_DISABLE)) begin
			// stopping the running system clock would hang the core
			apply = (sel_reg != sys_src_reg);
		end else if (i_sel_wr && cmd_active_reg && !csr_access) begin
			// the held command lands on the source picked next, unless it is a disable of the system source
			apply = (i_sel_wdata != sys_src_reg) || cmd_enable_reg;
			apply_idx = i_sel_wdata;
			apply_enable = cmd_enable_reg;
		end
	end

	// -----------------------------------------------------------------
	// control state
	// -----------------------------------------------------------------
	always_comb begin
		sel_next = sel_reg;
		sys_src_next = sys_src_reg;
		cmd_active_next = cmd_active_reg;
		cmd_enable_next = cmd_enable_reg;
		gain_ok_next = gain_ok_reg;
		switched_next = switched_reg;
		rdata_next = rdata_reg;

		if (change_en && ((csr_cmd == clock_switch_pkg::CMD_ENABLE) ||
				(csr_cmd == clock_switch_pkg::CMD_DISABLE))) begin
			cmd_active_next = 1'b1;
			cmd_enable_next = (csr_cmd == clock_switch_pkg::CMD_ENABLE);
		end else if (csr_access) begin
			// any read or write of the control word drops the held command
			cmd_active_next = 1'b0;
		end

		// a switch to a source that has not started yet is ignored
		if (change_en && (csr_cmd == clock_switch_pkg::CMD_SWITCH) && osc_ready[sel_reg]) begin
			sys_src_next = sel_reg;
			switched_next = 1'b1;
		end

		if (i_sel_wr) begin
			sel_next = i_sel_wdata;
			if (i_sel_wdata == `CSC_SRC_XTAL) begin
				gain_ok_next = 1'b1;
			end else if (osc_en[`CSC_SRC_XTAL]) begin
				gain_ok_next = 1'b0;
			end
		end

		if (i_csr_rd) begin
			rdata_next = '0;
			rdata_next[`CSC_STAT_SRC_MSB:`CSC_STAT_SRC_LSB] = sys_src_reg;
			rdata_next[`CSC_STAT_GAIN_OK_BIT] = gain_ok_reg;
			rdata_next[`CSC_STAT_SWITCHED_BIT] = switched_reg;
			rdata_next[`CSC_STAT_CMD_ACTIVE_BIT] = cmd_active_reg;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			sel_reg <= `CSC_SRC_RESET;
			sys_src_reg <= `CSC_SRC_RESET;
			cmd_active_reg <= 1'b0;
			cmd_enable_reg <= 1'b0;
			gain_ok_reg <= 1'b1;
			switched_reg <= 1'b0;
			rdata_reg <= `CSC_RDATA_RESET;
		end else if (i_ce) begin
			sel_reg <= sel_next;
			sys_src_reg <= sys_src_next;
			cmd_active_reg <= cmd_active_next;
			cmd_enable_reg <= cmd_enable_next;
			gain_ok_reg <= gain_ok_next;
			switched_reg <= switched_next;
			rdata_reg <= rdata_next;
		end
	end

	// -----------------------------------------------------------------
	// flash and eeprom programming
	// -----------------------------------------------------------------
	always_comb begin
		nvm_state_next = nvm_state_reg;
		prog_cnt_next = prog_cnt_reg;
		prog_fail_next = prog_fail_reg;
		done_next = 1'b0;
		fail_next = fail_reg;
		case (nvm_state_reg)
			clock_switch_pkg::NVM_IDLE: begin
				if (i_nvm_req) begin
					nvm_state_next = clock_switch_pkg::NVM_BUSY;
					prog_cnt_next = '0;
					// after any switch only the rc clock programs reliably
					prog_fail_next = switched_reg && (sys_src_reg != `CSC_SRC_RC);
				end
			end
			clock_switch_pkg::NVM_BUSY: begin
				if (switched_reg && (sys_src_reg != `CSC_SRC_RC)) begin
					prog_fail_next = 1'b1;
				end
				if (prog_cnt_reg == PROG_LAST) begin
					nvm_state_next = clock_switch_pkg::NVM_IDLE;
					done_next = 1'b1;
					fail_next = prog_fail_next;
				end else begin
					prog_cnt_next = prog_cnt_reg + `CSC_CNT_W'(1);
				end
			end
			default: begin
				nvm_state_next = clock_switch_pkg::NVM_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			nvm_state_reg <= clock_switch_pkg::NVM_IDLE;
			prog_cnt_reg <= '0;
			prog_fail_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
		end else if (i_ce) begin
			nvm_state_reg <= nvm_state_next;
			prog_cnt_reg <= prog_cnt_next;
			prog_fail_reg <= prog_fail_next;
			done_reg <= done_next;
			fail_reg <= fail_next;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign o_csr_rdata = rdata_reg;
	assign o_sel_value = sel_reg;
	assign o_sys_src = sys_src_reg;
	assign o_osc_en = osc_en;
	assign o_osc_ready = osc_ready;
	assign o_xtal_gain_ok = gain_ok_reg;
	assign o_cmd_active = cmd_active_reg;
	assign o_nvm_busy = (nvm_state_reg == clock_switch_pkg::NVM_BUSY);
	assign o_nvm_done = done_reg;
	assign o_nvm_fail = fail_reg;

endmodule // clock_source_switch_ctrl

// file: design/osc_enable_bank.sv
// oscillator enable bits with per-source start-up timers
`timescale 1ns/1ps
`include "clock_switch_regs.svh"

module osc_enable_bank (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_apply,
	input wire logic [`CSC_SRC_W-1:0] i_idx,
	input wire logic i_enable,
	output logic [`CSC_SRC_NUM-1:0] o_en,
	output logic [`CSC_SRC_NUM-1:0] o_ready
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [`CSC_SRC_NUM-1:0] en_reg;
	logic [`CSC_SRC_NUM-1:0] en_next;
	logic [`CSC_SRC_NUM-1:0] ready_reg;
	logic [`CSC_SRC_NUM-1:0] ready_next;
	logic [`CSC_CNT_W-1:0] cnt_reg [`CSC_SRC_NUM];
	logic [`CSC_CNT_W-1:0] cnt_next [`CSC_SRC_NUM];

	localparam logic [`CSC_CNT_W-1:0] START_LAST = `CSC_CNT_W'(`CSC_OSC_START_CYC - 1);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		en_next = en_reg;
		ready_next = ready_reg;
		for (int i = 0; i < `CSC_SRC_NUM; i++) begin
			cnt_next[i] = cnt_reg[i];
			// apart from the rc source at reset, a source counts as ready only after its start-up time
			if (!en_reg[i]) begin
				cnt_next[i] = '0;
				ready_next[i] = 1'b0;
			end else if (!ready_reg[i]) begin
				if (cnt_reg[i] == START_LAST) begin
					ready_next[i] = 1'b1;
				end else begin
					cnt_next[i] = cnt_reg[i] + `CSC_CNT_W'(1);
				end
			end
		end
		if (i_apply) begin
			en_next[i_idx] = i_enable;
			if (!i_enable) begin
				ready_next[i_idx] = 1'b0;
				cnt_next[i_idx] = '0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			en_reg <= `CSC_OSC_EN_RESET;
			ready_reg <= `CSC_OSC_EN_RESET;
			for (int i = 0; i < `CSC_SRC_NUM; i++) begin
				cnt_reg[i] <= '0;
			end
		end else if (i_ce) begin
			en_reg <= en_next;
			ready_reg <= ready_next;
			for (int i = 0; i < `CSC_SRC_NUM; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
		end
	end

	assign o_en = en_reg;
	assign o_ready = ready_reg;

endmodule // osc_enable_bank

// file: inc/clock_switch_pkg.sv
// types of the clock source switching control
package clock_switch_pkg;

	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_DISABLE = 2'h1,
		CMD_ENABLE = 2'h2,
		CMD_SWITCH = 2'h3
	} clk_cmd_t;

	typedef enum logic [1:0] {
		NVM_IDLE = 2'h1,
		NVM_BUSY = 2'h2
	} nvm_state_t;

endpackage

// file: inc/clock_switch_regs.svh
// constants of the clock source switching control
`ifndef CLOCK_SWITCH_REGS_SVH
`define CLOCK_SWITCH_REGS_SVH

// -----------------------------------------------------------------
// clock switch control word layout
// -----------------------------------------------------------------
`define CSC_DATA_W 8
`define CSC_CHANGE_ENABLE_BIT 7
`define CSC_CMD_LSB 0
`define CSC_CMD_MSB 1

// -----------------------------------------------------------------
// clock source select value and source indices
// -----------------------------------------------------------------
`define CSC_SRC_W 2
`define CSC_SRC_NUM 4
`define CSC_SRC_RC 2'h0
`define CSC_SRC_WD 2'h1
`define CSC_SRC_XTAL 2'h2
`define CSC_SRC_EXT 2'h3

// -----------------------------------------------------------------
// status read-back layout
// -----------------------------------------------------------------
`define CSC_STAT_SRC_LSB 0
`define CSC_STAT_SRC_MSB 1
`define CSC_STAT_GAIN_OK_BIT 4
`define CSC_STAT_SWITCHED_BIT 5
`define CSC_STAT_CMD_ACTIVE_BIT 6

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CSC_SRC_RESET 2'h0
`define CSC_OSC_EN_RESET 4'h1
`define CSC_RDATA_RESET 8'h00

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CSC_CLK_PERIOD_NS 8
`define CSC_OSC_START_NS 2000
`define CSC_OSC_START_CYC ((`CSC_OSC_START_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_NVM_PROG_NS 1000
`define CSC_NVM_PROG_CYC ((`CSC_NVM_PROG_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_CNT_W 9

`endif

// file: test/clock_source_switch_ctrl_props.sv
// checker of the clock source switching control ports
`timescale 1ns/1ps
`include "clock_switch_regs.svh"

module clock_source_switch_ctrl_props (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_csr_wr,
	input wire logic i_csr_rd,
	input wire logic [`CSC_DATA_W-1:0] i_csr_wdata,
	input wire logic i_sel_wr,
	input wire logic [`CSC_SRC_W-1:0] i_sel_wdata,
	input wire logic [`CSC_DATA_W-1:0] o_csr_rdata,
	input wire logic [`CSC_SRC_W-1:0] o_sys_src,
	input wire logic [`CSC_SRC_NUM-1:0] o_osc_en,
	input wire logic o_xtal_gain_ok,
	input wire logic o_cmd_active,
	input wire logic o_nvm_busy,
	input wire logic o_nvm_done,
	input wire logic o_nvm_fail
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	wire logic held_cmd;
	wire logic access;
	assign held_cmd = i_csr_wdata[7] && (i_csr_wdata[1:0] == 2'h1 || i_csr_wdata[1:0] == 2'h2);
	assign access = i_csr_wr || i_csr_rd;
	property p_cmd_set;
		i_ce && i_csr_wr && held_cmd |=> o_cmd_active;
	endproperty
	a_cmd_set: assert property (p_cmd_set) else $error("command not held");
	property p_cmd_hold;
		i_ce && o_cmd_active && !access |=> o_cmd_active;
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped early");
	property p_cmd_clear;
		i_ce && access && !(i_csr_wr && held_cmd) |=> !o_cmd_active;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("command not cleared");
	property p_no_reapply;
		i_ce && !o_cmd_active && !i_csr_wr |=> o_osc_en == $past(o_osc_en);
	endproperty
	a_no_reapply: assert property (p_no_reapply) else $error("enables moved");
	property p_gain_lost;
		i_ce && i_sel_wr && o_osc_en[2] && i_sel_wdata != `CSC_SRC_XTAL |=> !o_xtal_gain_ok;
	endproperty
	a_gain_lost: assert property (p_gain_lost) else $error("gain kept");
	property p_gain_set;
		i_ce && i_sel_wr && i_sel_wdata == `CSC_SRC_XTAL |=> o_xtal_gain_ok;
	endproperty
	a_gain_set: assert property (p_gain_set) else $error("gain not restored");
	property p_nvm_len;
		$rose(o_nvm_busy) |-> ##125 o_nvm_done;
	endproperty
	a_nvm_len: assert property (p_nvm_len) else $error("programming length");
	property p_nvm_fail;
		o_nvm_done && $past(o_sys_src) != `CSC_SRC_RC && o_csr_rdata[5] |-> o_nvm_fail;
	endproperty
	a_nvm_fail: assert property (p_nvm_fail) else $error("programming passed off rc");
	c_reapply: cover property (i_sel_wr && o_cmd_active && !access);
	c_gain: cover property (i_sel_wr && o_osc_en[2]);
	c_done: cover property (o_nvm_done && o_nvm_fail);
endmodule // clock_source_switch_ctrl_props

bind clock_source_switch_ctrl clock_source_switch_ctrl_props clock_source_switch_ctrl_props_inst (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_csr_wr(i_csr_wr),
	.i_csr_rd(i_csr_rd), .i_csr_wdata(i_csr_wdata), .i_sel_wr(i_sel_wr),
	.i_sel_wdata(i_sel_wdata), .o_csr_rdata(o_csr_rdata), .o_sys_src(o_sys_src),
	.o_osc_en(o_osc_en), .o_xtal_gain_ok(o_xtal_gain_ok), .o_cmd_active(o_cmd_active),
	.o_nvm_busy(o_nvm_busy), .o_nvm_done(o_nvm_done), .o_nvm_fail(o_nvm_fail));

// file: test/clock_source_switch_ctrl_tb_top.sv
// self-checking testbench of the clock source switching control
`timescale 1ns/1ps
`include "clock_switch_regs.svh"

module clock_source_switch_ctrl_tb_top;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_ce = 1'b1;
	logic i_csr_wr = 1'b0;
	logic i_csr_rd = 1'b0;
	logic [7:0] i_csr_wdata = 8'h00;
	logic i_sel_wr = 1'b0;
	logic [1:0] i_sel_wdata = 2'h0;
	logic i_nvm_req = 1'b0;
	logic [7:0] o_csr_rdata;
	logic [1:0] o_sel_value;
	logic [1:0] o_sys_src;
	logic [3:0] o_osc_en;
	logic [3:0] o_osc_ready;
	logic o_xtal_gain_ok;
	logic o_cmd_active;
	logic o_nvm_busy;
	logic o_nvm_done;
	logic o_nvm_fail;
	int n_errors = 0;
	int comparisons = 0;

	clock_source_switch_ctrl clock_source_switch_ctrl_inst (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .i_ce(i_ce), .i_csr_wr(i_csr_wr), .i_csr_rd(i_csr_rd),
		.i_csr_wdata(i_csr_wdata), .i_sel_wr(i_sel_wr), .i_sel_wdata(i_sel_wdata),
		.i_nvm_req(i_nvm_req), .o_csr_rdata(o_csr_rdata), .o_sel_value(o_sel_value),
		.o_sys_src(o_sys_src), .o_osc_en(o_osc_en), .o_osc_ready(o_osc_ready),
		.o_xtal_gain_ok(o_xtal_gain_ok), .o_cmd_active(o_cmd_active),
		.o_nvm_busy(o_nvm_busy), .o_nvm_done(o_nvm_done), .o_nvm_fail(o_nvm_fail));

	always #4 i_ref_clk = ~i_ref_clk;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// strobes last one cycle; results are looked at once the next edge has landed
	task automatic csr(input logic [7:0] d, input logic rd);
		@(posedge i_ref_clk);
		i_csr_wr <= !rd;
		i_csr_rd <= rd;
		i_csr_wdata <= d;
		@(posedge i_ref_clk);
		i_csr_wr <= 1'b0;
		i_csr_rd <= 1'b0;
		#1;
	endtask

	task automatic sel(input logic [1:0] v);
		@(posedge i_ref_clk);
		i_sel_wr <= 1'b1;
		i_sel_wdata <= v;
		@(posedge i_ref_clk);
		i_sel_wr <= 1'b0;
		#1;
	endtask

	task automatic program_nvm(input logic exp_fail);
		int i;
		i = 0;
		@(posedge i_ref_clk);
		i_nvm_req <= 1'b1;
		@(posedge i_ref_clk);
		i_nvm_req <= 1'b0;
		#1;
		check(o_nvm_busy, 1'b1);
		while (o_nvm_done !== 1'b1 && i < 200) begin
			@(posedge i_ref_clk);
			#1;
			i++;
		end
		check(8'(i), 8'(`CSC_NVM_PROG_CYC));
		check(o_nvm_busy, 1'b0);
		check(8'(o_nvm_fail), 8'(exp_fail));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_latch();
		check(o_osc_en, 4'h1);
		check(o_sys_src, 2'h0);
		check(o_cmd_active, 1'b0);
		sel(2'h2);
		csr(8'h82, 1'b0);
		check(o_cmd_active, 1'b1);
		check(o_osc_en, 4'h5);
		repeat (3) @(posedge i_ref_clk);
		#1;
		check(o_cmd_active, 1'b1);
		csr(8'h80, 1'b0);
		check(o_cmd_active, 1'b0);
		csr(8'h82, 1'b0);
		csr(8'h00, 1'b1);
		check(o_csr_rdata[6], 1'b1);
		check(o_cmd_active, 1'b0);
		// a command written while the clock enable is low must leave no trace
		@(posedge i_ref_clk);
		i_ce <= 1'b0;
		csr(8'h82, 1'b0);
		check(o_cmd_active, 1'b0);
		@(posedge i_ref_clk);
		i_ce <= 1'b1;
		$display("test latch done");
	endtask

	task automatic t_reapply();
		csr(8'h82, 1'b0);
		sel(2'h1);
		check(o_osc_en, 4'h7);
		check(o_sel_value, 2'h1);
		csr(8'h80, 1'b0);
		sel(2'h3);
		check(o_osc_en, 4'h7);
		sel(2'h1);
		csr(8'h81, 1'b0);
		check(o_osc_en, 4'h5);
		// a held disable must not stop the running system source
		sel(2'h0);
		check(o_osc_en, 4'h5);
		csr(8'h80, 1'b0);
		check(o_cmd_active, 1'b0);
		$display("test reapply done");
	endtask

	task automatic t_gain();
		int i;
		for (i = 0; i < 300 && o_osc_ready[2] !== 1'b1; i++) @(posedge i_ref_clk);
		#1;
		check(o_osc_ready, 4'h5);
		sel(2'h2);
		check(o_xtal_gain_ok, 1'b1);
		csr(8'h83, 1'b0);
		check(o_sys_src, 2'h2);
		csr(8'h80, 1'b0);
		sel(2'h0);
		check(o_xtal_gain_ok, 1'b0);
		sel(2'h2);
		check(o_xtal_gain_ok, 1'b1);
		$display("test gain done");
	endtask

	task automatic t_nvm();
		csr(8'h00, 1'b1);
		check(o_csr_rdata[5], 1'b1);
		check(o_csr_rdata[1:0], 2'h2);
		check(o_csr_rdata[4], 1'b1);
		program_nvm(1'b1);
		sel(2'h0);
		csr(8'h83, 1'b0);
		csr(8'h80, 1'b0);
		check(o_sys_src, 2'h0);
		program_nvm(1'b0);
		$display("test nvm done");
	endtask

	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		#1;
		t_latch();
		t_reapply();
		t_gain();
		t_nvm();
		close_out();
	end

	// the tests need well under 2000 cycles
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule // clock_source_switch_ctrl_tb_top
